// ---- scu_top.sv ----
// smart card uart: avalon registers, direct/inverse framing, parity error signal
// ============================================================================
`timescale 1ns/10ps
module scu_top (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        transfer_clock,
  input  wire logic        serial_receive_pin,
  output logic             serial_transmit_pin_o,
  output logic             serial_transmit_pin_oe,
  output logic             irq
);

  // ==========================================================================
  // reset release
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  wire rst_sync_n = rst_sync_ff;

  // ==========================================================================
  // pin sampling
  scu_pin_if pins ();

  scu_pin_sync u_pin_sync (
    .clk_sys            (clk_sys),
    .rst_sync_n         (rst_sync_n),
    .transfer_clock     (transfer_clock),
    .serial_receive_pin (serial_receive_pin),
    .pins               (pins.src)
  );

  wire rise = pins.xclk_rise;
  wire fall = pins.xclk_fall;
  wire rxd  = pins.rx_lvl;

  // ==========================================================================
  // state declarations
  logic                  wait_ff;
  logic [31:0]           rdata_ff;
  logic [1:0]            mode_ff;
  logic                  order_ff;
  logic [3:0]            ctrl1_ff;
  logic [2:0]            mask_ff;
  logic [2:0]            stat_ff;
  logic                  irq_ff;
  logic [7:0]            txbuf_ff;
  logic                  tx_full_ff;
  logic                  tx_busy_ff;
  logic [10:0]           tx_sh_ff;
  logic [3:0]            tx_cnt_ff;
  logic [3:0]            tx_nbits_ff;
  logic                  tx_line_ff;
  logic                  oe_ff;
  logic                  pin_o_ff;
  scu_pkg::scu_rx_state_t rx_st_ff;
  logic [2:0]            rx_cnt_ff;
  logic [7:0]            rx_sh_ff;
  logic                  rx_acc_ff;
  logic [7:0]            rxbuf_ff;
  logic                  rx_full_ff;
  logic                  ovr_ff;
  logic                  frm_ff;
  logic                  per_ff;
  logic                  err_sig_ff;
  logic                  rx_arm_ff;

  // ==========================================================================
  // avalon decode: one wait cycle, then the request completes
  wire bus_req   = avs_read | avs_write;
  wire bus_first = bus_req & wait_ff;
  wire do_wr     = avs_write & ~wait_ff & avs_byteenable[0];
  wire do_rd     = avs_read & ~wait_ff;
  wire sel_tx    = avs_address == scu_pkg::REG_TXBUF;
  wire sel_rx    = avs_address == scu_pkg::REG_RXBUF;
  wire sel_mode  = avs_address == scu_pkg::REG_MODE;
  wire sel_c0    = avs_address == scu_pkg::REG_CTRL0;
  wire sel_c1    = avs_address == scu_pkg::REG_CTRL1;
  wire sel_stat  = avs_address == scu_pkg::REG_IRQ_STAT;
  wire sel_mask  = avs_address == scu_pkg::REG_IRQ_MASK;
  wire rd_rxbuf  = do_rd & sel_rx;

  // control bit taps
  wire par_en    = mode_ff[scu_pkg::MODE_PAR_EN];
  wire par_even  = mode_ff[scu_pkg::MODE_PAR_EVEN];
  wire tx_en     = ctrl1_ff[scu_pkg::CTRL1_TX_EN];
  wire rx_en     = ctrl1_ff[scu_pkg::CTRL1_RX_EN];
  wire invert    = ctrl1_ff[scu_pkg::CTRL1_INVERT];
  wire err_out   = ctrl1_ff[scu_pkg::CTRL1_ERR_OUT];
  wire sum_err   = ovr_ff | frm_ff | per_ff;

  // read data selection; unmapped addresses read zero
  wire [31:0] rx_word  = {20'h0_0000, sum_err, per_ff, frm_ff, ovr_ff, rxbuf_ff};
  wire [31:0] c1_word  = {25'h000_0000, tx_full_ff, rx_full_ff, tx_busy_ff, ctrl1_ff};
  wire [31:0] rd_mux   = sel_rx   ? rx_word :
                         sel_tx   ? {24'h00_0000, txbuf_ff} :
                         sel_mode ? {30'h0000_0000, mode_ff} :
                         sel_c0   ? {31'h0000_0000, order_ff} :
                         sel_c1   ? c1_word :
                         sel_stat ? {29'h0000_0000, stat_ff} :
                         sel_mask ? {29'h0000_0000, mask_ff} : 32'h0000_0000;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wait_ff  <= ~bus_first;
      rdata_ff <= (bus_first & avs_read) ? rd_mux : rdata_ff;
    end
  end

  // software-written configuration
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_ff  <= scu_pkg::MODE_RST;
      order_ff <= 1'b0;
      ctrl1_ff <= scu_pkg::CTRL1_RST;
      mask_ff  <= scu_pkg::IRQ_RST;
    end else begin
      if (do_wr && sel_mode) mode_ff  <= avs_writedata[1:0];
      if (do_wr && sel_c0)   order_ff <= avs_writedata[scu_pkg::CTRL0_MSB];
      if (do_wr && sel_c1)   ctrl1_ff <= avs_writedata[3:0];
      if (do_wr && sel_mask) mask_ff  <= avs_writedata[2:0];
    end
  end

  // ==========================================================================
  // transmitter: bits change on transfer clock falling edges
  wire [7:0]  tx_lvl   = invert ? ~txbuf_ff : txbuf_ff;
  wire [7:0]  tx_rev   = {<<{tx_lvl}};
  wire [7:0]  tx_ord   = order_ff ? tx_rev : tx_lvl;
  wire        tx_par   = (^tx_ord) ^ ~par_even;
  wire [10:0] frame    = {1'b1, (par_en ? tx_par : 1'b1), tx_ord, 1'b0};
  wire [3:0]  nbits    = par_en ? scu_pkg::TX_BITS_PAR : scu_pkg::TX_BITS_NOPAR;
  wire        tx_start = fall & ~tx_busy_ff & tx_full_ff & tx_en;
  wire        tx_last  = tx_cnt_ff == tx_nbits_ff;
  wire        tx_step  = fall & tx_busy_ff & ~tx_last;
  wire        tx_end   = fall & tx_busy_ff & tx_last;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      txbuf_ff   <= 8'h00;
      tx_full_ff <= 1'b0;
    end else begin
      if (do_wr && sel_tx) txbuf_ff <= avs_writedata[7:0];
      // a write in the start cycle keeps the buffer marked full
      tx_full_ff <= (do_wr & sel_tx) | (tx_full_ff & ~tx_start);
    end
  end

  // shift register holds the rest of the frame, lsb goes to the line next
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_busy_ff  <= 1'b0;
      tx_sh_ff    <= 11'h7FF;
      tx_cnt_ff   <= 4'h0;
      tx_nbits_ff <= scu_pkg::TX_BITS_PAR;
      tx_line_ff  <= 1'b1;
    end else if (tx_start) begin
      tx_busy_ff  <= 1'b1;
      tx_sh_ff    <= {1'b1, frame[10:1]};
      tx_cnt_ff   <= 4'h1;
      tx_nbits_ff <= nbits;
      tx_line_ff  <= frame[0];
    end else if (tx_step) begin
      tx_sh_ff    <= {1'b1, tx_sh_ff[10:1]};
      tx_cnt_ff   <= tx_cnt_ff + 4'h1;
      tx_line_ff  <= tx_sh_ff[0];
    end else if (tx_end) begin
      tx_busy_ff  <= 1'b0;
      tx_line_ff  <= 1'b1;
    end
  end

  // ==========================================================================
  // receiver: the line is sampled on transfer clock rising edges
  wire [7:0] rx_rev  = {<<{rx_sh_ff}};
  wire [7:0] rx_ord  = order_ff ? rx_rev : rx_sh_ff;
  wire [7:0] rx_data = invert ? ~rx_ord : rx_ord;
  // own error signal holds the line low; re-arm only once the line reads high again
  wire       rx_go   = rise & rx_en & ~rxd & ~err_sig_ff & rx_arm_ff;
  wire       rx_done = rise & (rx_st_ff == scu_pkg::SCU_RX_STOP);
  wire       new_frm = ~rxd;
  wire       new_per = par_en & rx_acc_ff;
  wire       new_err = new_frm | new_per | rx_full_ff;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_st_ff  <= scu_pkg::SCU_RX_IDLE;
      rx_cnt_ff <= 3'h0;
      rx_sh_ff  <= 8'h00;
      rx_acc_ff <= 1'b0;
    end else begin
      case (rx_st_ff)
        scu_pkg::SCU_RX_IDLE: begin
          rx_cnt_ff <= 3'h0;
          rx_acc_ff <= 1'b0;
          if (rx_go) rx_st_ff <= scu_pkg::SCU_RX_DATA;
        end
        scu_pkg::SCU_RX_DATA: begin
          if (rise) begin
            rx_sh_ff  <= {rxd, rx_sh_ff[7:1]};
            rx_acc_ff <= rx_acc_ff ^ rxd;
            rx_cnt_ff <= rx_cnt_ff + 3'h1;
            if (rx_cnt_ff == scu_pkg::RX_LAST_DATA) begin
              rx_st_ff <= par_en ? scu_pkg::SCU_RX_PAR : scu_pkg::SCU_RX_STOP;
            end
          end
        end
        scu_pkg::SCU_RX_PAR: begin
          // acc turns into "parity bad": even wants xor 0, odd wants xor 1
          if (rise) begin
            rx_acc_ff <= rx_acc_ff ^ rxd ^ ~par_even;
            rx_st_ff  <= scu_pkg::SCU_RX_STOP;
          end
        end
        scu_pkg::SCU_RX_STOP: begin
          if (rise) rx_st_ff <= scu_pkg::SCU_RX_IDLE;
        end
        default: rx_st_ff <= scu_pkg::SCU_RX_IDLE;
      endcase
    end
  end

  // receive buffer and error flags; a completing character beats a clearing read
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rxbuf_ff   <= 8'h00;
      rx_full_ff <= 1'b0;
      ovr_ff     <= 1'b0;
      frm_ff     <= 1'b0;
      per_ff     <= 1'b0;
    end else if (rx_done) begin
      rxbuf_ff   <= rx_data;
      rx_full_ff <= 1'b1;
      ovr_ff     <= rx_full_ff;
      frm_ff     <= new_frm;
      per_ff     <= new_per;
    end else begin
      rx_full_ff <= rx_full_ff & ~rd_rxbuf;
      per_ff     <= per_ff & ~rd_rxbuf;
      // overrun and framing survive reads; they clear when reception is switched off or the next character reloads them
      ovr_ff     <= ovr_ff & rx_en;
      frm_ff     <= frm_ff & rx_en;
    end
  end

  // ==========================================================================
  // parity error signal: starts at the stop-bit sample, ends on a buffer read
  wire sig_set = rx_done & new_per & err_out;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      err_sig_ff <= 1'b0;
      rx_arm_ff  <= 1'b0;
    end else begin
      err_sig_ff <= sig_set | (err_sig_ff & ~rd_rxbuf);
      rx_arm_ff  <= ~err_sig_ff & (rx_arm_ff | rxd);  // released line lags the sampler
    end
  end

  // open-drain line: only ever pull low, otherwise release to the pull-up
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      oe_ff    <= 1'b0;
      pin_o_ff <= 1'b0;
    end else begin
      oe_ff    <= ~tx_line_ff | err_sig_ff;
      pin_o_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // interrupt status (write one to clear, a new event wins) and mask
  wire [2:0] irq_ev  = {rx_done & new_err, rx_done, tx_end};
  wire [2:0] irq_clr = (do_wr & sel_stat) ? avs_writedata[2:0] : 3'h0;
  wire [2:0] nxt_stat = (stat_ff & ~irq_clr) | irq_ev;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stat_ff <= scu_pkg::IRQ_RST;
      irq_ff  <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      irq_ff  <= |(nxt_stat & mask_ff);
    end
  end

  // ==========================================================================
  // outputs
  assign avs_readdata           = rdata_ff;
  assign avs_waitrequest        = wait_ff;
  assign serial_transmit_pin_o  = pin_o_ff;
  assign serial_transmit_pin_oe = oe_ff;
  assign irq                    = irq_ff;

endmodule : scu_top

// ---- scu_pkg.sv ----
// constants and types shared by the smart card uart files
package scu_pkg;

  // ==========================================================================
  // register map (byte addresses on the avalon slave)
  localparam int unsigned ADDR_W       = 5;
  localparam logic [4:0]  REG_TXBUF    = 5'h00;
  localparam logic [4:0]  REG_RXBUF    = 5'h04;
  localparam logic [4:0]  REG_MODE     = 5'h08;
  localparam logic [4:0]  REG_CTRL0    = 5'h0C;
  localparam logic [4:0]  REG_CTRL1    = 5'h10;
  localparam logic [4:0]  REG_IRQ_STAT = 5'h14;
  localparam logic [4:0]  REG_IRQ_MASK = 5'h18;

  // ==========================================================================
  // field positions
  localparam int unsigned MODE_PAR_EN    = 0;  // parity_enable
  localparam int unsigned MODE_PAR_EVEN  = 1;  // parity_odd_even_select, 1 = even
  localparam int unsigned CTRL0_MSB      = 0;  // bit_order_select, 1 = msb first
  localparam int unsigned CTRL1_TX_EN    = 0;
  localparam int unsigned CTRL1_RX_EN    = 1;
  localparam int unsigned CTRL1_INVERT   = 2;  // data_logic_invert
  localparam int unsigned CTRL1_ERR_OUT  = 3;  // error_signal_output_enable
  localparam int unsigned CTRL1_TX_BUSY  = 4;
  localparam int unsigned CTRL1_RX_FULL  = 5;  // receive_complete_flag
  localparam int unsigned CTRL1_TX_FULL  = 6;
  localparam int unsigned RXBUF_OVR      = 8;
  localparam int unsigned RXBUF_FRM      = 9;
  localparam int unsigned RXBUF_PAR      = 10;
  localparam int unsigned RXBUF_SUM      = 11;
  localparam int unsigned IRQ_TXC        = 0;
  localparam int unsigned IRQ_RXC        = 1;
  localparam int unsigned IRQ_ERR        = 2;

  // ==========================================================================
  // widths, reset values and frame lengths
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned IRQ_W          = 3;
  localparam logic [1:0]  MODE_RST       = 2'h0;
  localparam logic [3:0]  CTRL1_RST      = 4'h0;
  localparam logic [2:0]  IRQ_RST        = 3'h0;
  localparam logic [3:0]  TX_BITS_PAR    = 4'hB;  // start, 8 data, parity, stop
  localparam logic [3:0]  TX_BITS_NOPAR  = 4'hA;  // start, 8 data, stop
  localparam logic [2:0]  RX_LAST_DATA   = 3'h7;

  // receiver sequence
  typedef enum logic [1:0] {
    SCU_RX_IDLE,
    SCU_RX_DATA,
    SCU_RX_PAR,
    SCU_RX_STOP
  } scu_rx_state_t;

endpackage : scu_pkg

// ---- scu_pin_if.sv ----
// synchronised pin events passed from the pin sampler to the uart core
`timescale 1ns/10ps
interface scu_pin_if;
  logic xclk_rise;  // one-cycle pulse on a transfer clock rising edge
  logic xclk_fall;  // one-cycle pulse on a transfer clock falling edge
  logic rx_lvl;     // synchronised shared line level

  modport src (output xclk_rise, output xclk_fall, output rx_lvl);
  modport dst (input xclk_rise, input xclk_fall, input rx_lvl);
endinterface : scu_pin_if

// ---- scu_pin_sync.sv ----
// two-stage synchronisers and edge detection for the transfer clock and line
`timescale 1ns/10ps
module scu_pin_sync (
  input  wire logic clk_sys,
  input  wire logic rst_sync_n,
  input  wire logic transfer_clock,
  input  wire logic serial_receive_pin,
  scu_pin_if.src    pins
);

  logic clk_meta_ff;
  logic clk_sync_ff;
  logic clk_last_ff;
  logic rx_meta_ff;
  logic rx_sync_ff;
  logic rise_ff;
  logic fall_ff;

  // ==========================================================================
  // synchronisers: the meta stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      clk_meta_ff <= 1'b0;
      clk_sync_ff <= 1'b0;
      clk_last_ff <= 1'b0;
      rx_meta_ff  <= 1'b1;  // pulled-up line idles high
      rx_sync_ff  <= 1'b1;
    end else begin
      clk_meta_ff <= transfer_clock;
      clk_sync_ff <= clk_meta_ff;
      clk_last_ff <= clk_sync_ff;
      rx_meta_ff  <= serial_receive_pin;
      rx_sync_ff  <= rx_meta_ff;
    end
  end

  // edge pulses are registered so the core sees clean single-cycle strobes
  wire nxt_rise = clk_sync_ff & ~clk_last_ff;
  wire nxt_fall = ~clk_sync_ff & clk_last_ff;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      rise_ff <= nxt_rise;
      fall_ff <= nxt_fall;
    end
  end

  assign pins.xclk_rise = rise_ff;
  assign pins.xclk_fall = fall_ff;
  assign pins.rx_lvl    = rx_sync_ff;  // same age as the edge pulses' source

endmodule : scu_pin_sync

// ---- scu_card.sv ----
// behavioural smart card on the shared, pulled-up data line
`timescale 1ns/10ps
module scu_card (
  input  wire logic transfer_clock,
  input  wire logic line,
  output logic      card_low
);
  // ==========================================================================
  // line driver: the card only ever pulls low; the pull-up gives the high
  initial card_low = 1'b0;

  // send one character; bits change on transfer clock falls, mid-bit for the reader
  task automatic send(input logic [7:0] lb, input logic p, input logic stop);
    @(negedge transfer_clock) card_low <= 1'b1;  // start bit
    for (int i = 0; i < 8; i++) begin
      @(negedge transfer_clock) card_low <= ~lb[i];
    end
    @(negedge transfer_clock) card_low <= ~p;
    @(negedge transfer_clock) card_low <= ~stop;  // a low stop forces a framing fault
    @(negedge transfer_clock) card_low <= 1'b0;  // released, pull-up takes over
  endtask : send

  // capture one frame as seen on the wire: [7:0] data in line order, [8] parity, [9] stop
  task automatic get_frame(output logic [9:0] f);
    int n;
    n = 0;
    do begin
      @(posedge transfer_clock);
      n++;
    end while (line !== 1'b0 && n < 40);
    for (int i = 0; i < 10; i++) begin
      @(posedge transfer_clock);
      f[i] = line;
    end
  endtask : get_frame
endmodule : scu_card

// ---- scu_top_sva.sv ----
// concurrent checks on the smart card uart top ports
`timescale 1ns/10ps
module scu_chk (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        transfer_clock,
  input wire logic        serial_receive_pin,
  input wire logic        serial_transmit_pin_o,
  input wire logic        serial_transmit_pin_oe,
  input wire logic        irq
);
  // ==========================================================================
  // helpers: cycles since the last transfer clock edge, receive buffer read
  logic       tc_ff;
  logic [5:0] age_ff;
  logic       wr1_ff;
  logic       wr2_ff;
  wire  logic       tc_edge = tc_ff != transfer_clock;
  wire  logic [5:0] nxt_age = tc_edge ? 6'h00 : (&age_ff ? age_ff : age_ff + 6'h01);
  wire  logic       rx_rd   = avs_read && !avs_waitrequest && avs_address == scu_pkg::REG_RXBUF;
  wire  logic       wr_seen = avs_write || wr1_ff || wr2_ff;

  // age saturates so a long idle span cannot wrap into a false "recent edge"
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tc_ff  <= 1'b0;
      age_ff <= 6'h3F;
      wr1_ff <= 1'b0;
      wr2_ff <= 1'b0;
    end else begin
      tc_ff  <= transfer_clock;
      age_ff <= nxt_age;
      wr1_ff <= avs_write;  // a mask write may raise irq two cycles later
      wr2_ff <= wr1_ff;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // assertions
  a_pin_o_low: assert property (!serial_transmit_pin_o)
    else $error("transmit pin output value not low");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_idle: assert property (!avs_read && !avs_write |-> avs_waitrequest)
    else $error("waitrequest low without a request");
  a_sum_flag: assert property (rx_rd |-> avs_readdata[11] == |avs_readdata[10:8])
    else $error("error sum flag disagrees with error flags");
  a_err_release: assert property (rx_rd && serial_transmit_pin_oe |-> ##[1:3] !serial_transmit_pin_oe)
    else $error("error signal not released after receive buffer read");
  a_oe_on_edge: assert property ($rose(serial_transmit_pin_oe) |-> age_ff <= 6'h0A)
    else $error("line pulled low away from a transfer clock edge");
  a_irq_on_edge: assert property ($rose(irq) && !wr_seen |-> age_ff <= 6'h0A)
    else $error("interrupt raised away from a transfer clock edge");

  // main scenarios
  c_irq_rise: cover property ($rose(irq));
  c_err_release: cover property (rx_rd && serial_transmit_pin_oe);
  c_line_drive: cover property ($rose(serial_transmit_pin_oe));
endmodule : scu_chk

bind scu_top scu_chk chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .transfer_clock(transfer_clock),
  .serial_receive_pin(serial_receive_pin), .serial_transmit_pin_o(serial_transmit_pin_o),
  .serial_transmit_pin_oe(serial_transmit_pin_oe), .irq(irq));

// ---- smart_card_uart_parity_format_tb.sv ----
// self-checking bench: registers, direct and inverse framing, parity error signal
`timescale 1ns/10ps
module smart_card_uart_parity_format_tb;
`define CHK(g, e) check_val(32'(g), 32'(e));
  logic        clk_sys = 1'b0;
  logic        tclk    = 1'b0;
  logic        rst_n, avs_read, avs_write, dut_o, dut_oe, irq, card_low;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic        avs_waitrequest;
  wire  logic  line = !(dut_oe || card_low);  // open drain with pull-up
  int          n_errors  = 0;
  int          tests_run = 0;

  always #2 clk_sys = ~clk_sys;
  // link clock free running, phase unrelated to the system clock
  always #62.5 tclk = ~tclk;

  scu_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .transfer_clock(tclk), .serial_receive_pin(line), .serial_transmit_pin_o(dut_o),
    .serial_transmit_pin_oe(dut_oe), .irq(irq));
  scu_card card_u (.transfer_clock(tclk), .line(line), .card_low(card_low));

  // ==========================================================================
  // common tasks
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check_val

  task automatic close_out();
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // request held until waitrequest is sampled low; a stuck slave counts as a mismatch
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50) n_errors++;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  // format bits: direct = even, d0 first; inverse = inverted, d7 first, odd
  function automatic logic [8:0] fmt(input logic [7:0] d, input logic inv);
    logic [7:0] lb;
    for (int i = 0; i < 8; i++) lb[i] = inv ? ~d[7 - i] : d[i];
    return {inv ? ~^lb : ^lb, lb};
  endfunction : fmt

  task automatic cfg(input logic inv, input logic err, input logic tx, input logic rx);
    wr(scu_pkg::REG_MODE, {6'h00, !inv, 1'b1});
    wr(scu_pkg::REG_CTRL0, {7'h00, inv});
    wr(scu_pkg::REG_CTRL1, {4'h0, err, inv, rx, tx});
  endtask : cfg

  // ==========================================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] q;
    logic [4:0]  a [6] = '{scu_pkg::REG_MODE, scu_pkg::REG_CTRL0, scu_pkg::REG_CTRL1,
                           scu_pkg::REG_IRQ_STAT, scu_pkg::REG_IRQ_MASK, 5'h1C};
    foreach (a[i]) begin
      bus(1'b0, a[i], 8'h00, q);
      `CHK(q, 32'h0000_0000)
    end
    wr(5'h1C, 8'hFF);
    bus(1'b0, 5'h1C, 8'h00, q);
    `CHK(q, 32'h0000_0000)
  endtask : t_regs

  // transmit one character, check the frame on the wire, then the completion status and interrupt
  task automatic t_tx(input logic inv, input logic [7:0] d);
    logic [9:0]  f;
    logic [8:0]  x;
    logic [31:0] q;
    x = fmt(d, inv);
    cfg(inv, 1'b0, 1'b1, 1'b0);
    wr(scu_pkg::REG_IRQ_STAT, 8'h07);
    wr(scu_pkg::REG_IRQ_MASK, 8'h01);
    wr(scu_pkg::REG_TXBUF, d);
    card_u.get_frame(f);
    `CHK(f[7:0], x[7:0])
    `CHK(f[9:8], {1'b1, x[8]})
    @(posedge clk_sys);
    bus(1'b0, scu_pkg::REG_IRQ_STAT, 8'h00, q);
    `CHK(q[0], 1'b0)
    @(negedge tclk);
    repeat (10) @(posedge clk_sys);
    `CHK({irq, line}, 2'b11)
    wr(scu_pkg::REG_IRQ_MASK, 8'h00);
  endtask : t_tx

  // receive one character from the card, optionally with bad parity or stop
  task automatic t_rx(input logic inv, input logic err, input logic [7:0] d,
                      input logic pbad, input logic stop);
    logic [8:0]  x;
    logic [31:0] q;
    x = fmt(d, inv);
    cfg(inv, err, 1'b0, 1'b1);
    card_u.send(x[7:0], x[8] ^ pbad, stop);
    repeat (4) @(posedge clk_sys);
    `CHK(dut_oe, pbad & err)
    `CHK(line, !(pbad & err))
    bus(1'b0, scu_pkg::REG_RXBUF, 8'h00, q);
    `CHK(q[7:0], d)
    `CHK(q[10:9], {pbad, !stop})
    `CHK(q[11], pbad | !stop)
    repeat (4) @(posedge clk_sys);
    `CHK({dut_oe, line}, 2'b01)
    bus(1'b0, scu_pkg::REG_RXBUF, 8'h00, q);
    `CHK(q[10], 1'b0)
  endtask : t_rx

  // error interrupt: raise, mask, unmask, clear one status bit only
  task automatic t_irq();
    logic [31:0] q;
    cfg(1'b0, 1'b1, 1'b0, 1'b1);
    wr(scu_pkg::REG_IRQ_STAT, 8'h07);
    wr(scu_pkg::REG_IRQ_MASK, 8'h04);
    card_u.send(8'h0F, 1'b1, 1'b1);
    repeat (4) @(posedge clk_sys);
    `CHK({irq, dut_oe}, 2'b11)
    wr(scu_pkg::REG_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    wr(scu_pkg::REG_IRQ_MASK, 8'h04);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b1)
    bus(1'b0, scu_pkg::REG_RXBUF, 8'h00, q);
    wr(scu_pkg::REG_IRQ_STAT, 8'h04);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    bus(1'b0, scu_pkg::REG_IRQ_STAT, 8'h00, q);
    `CHK(q[2:1], 2'b01)
  endtask : t_irq

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    rst_n         = 1'b0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_address   = 5'h00;
    avs_writedata = 32'h0000_0000;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    t_regs();
    t_tx(1'b0, 8'hB3);
    t_tx(1'b1, 8'h3B);
    t_rx(1'b0, 1'b0, 8'h5C, 1'b0, 1'b1);
    t_rx(1'b0, 1'b1, 8'h5C, 1'b1, 1'b1);
    t_rx(1'b0, 1'b0, 8'hA1, 1'b1, 1'b1);
    t_rx(1'b1, 1'b1, 8'hC5, 1'b0, 1'b1);
    t_rx(1'b1, 1'b1, 8'h1C, 1'b1, 1'b1);
    t_rx(1'b0, 1'b1, 8'h96, 1'b0, 1'b0);
    t_irq();
    close_out();
  end

  // the whole run needs about 15 us; this is a generous ceiling
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
endmodule : smart_card_uart_parity_format_tb
